// file: signal_keyer.v
/*
 Signal keyer control block: APB register file, source synchronisers,
 keying core and registered pin controls.
 Assumes an APB master on clk_sys, asynchronous carrier and data sources
 on src_in, and a pad ring that honours the pin-cut and slew outputs.
*/
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "keyer_map.vh"
`timescale 1ns/1ps
`default_nettype none
module signal_keyer #(
    parameter NSRC = 8
) (
    input  wire            clk_sys,
    input  wire            rst_n,
    input  wire            sleep_req,
    input  wire [NSRC-1:0] src_in,
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [11:0]     paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr,
    output reg             keyed_output_pin,
    output reg             slew_limit_on,
    output reg  [NSRC-1:0] src_pin_cut
);
    reg  [7:0]      mod_ctrl_q;
    reg  [7:0]      mod_ctrl_d;
    reg  [7:0]      carrier_high_ctrl_q;
    reg  [7:0]      carrier_high_ctrl_d;
    reg  [7:0]      carrier_low_ctrl_q;
    reg  [7:0]      carrier_low_ctrl_d;
    reg  [7:0]      src_ctrl_q;
    reg  [7:0]      src_ctrl_d;
    reg             status_q;
    reg             status_d;
    reg             pready_d;
    reg             pslverr_d;
    reg  [31:0]     prdata_d;
    reg             pin_d;
    reg             slew_d;
    reg  [7:0]      rd_mux;
    reg             hit;
    wire            keyer_enable;
    wire            keyer_pin_enable;
    wire            slew_limit_bit;
    wire            output_invert;
    wire            soft_data_value;
    wire [2:0]      carrier_high_sel;
    wire            carrier_high_invert;
    wire            carrier_high_pin_cut;
    wire [2:0]      carrier_low_sel;
    wire            carrier_low_invert;
    wire            carrier_low_pin_cut;
    wire [2:0]      data_sel;
    wire            data_source_pin_cut;
    wire            sel_mod;
    wire            sel_carrier_high;
    wire            sel_carrier_low;
    wire            sel_src;
    wire            access;
    wire            wr_en;
    wire            rd_en;
    wire [NSRC-1:0] src_sync;
    wire [NSRC-1:0] cut_d;
    wire            mixed;
    genvar          g;

    assign keyer_enable         = mod_ctrl_q[`MC_ENABLE_BIT];
    assign keyer_pin_enable     = mod_ctrl_q[`MC_PIN_EN_BIT];
    assign slew_limit_bit       = mod_ctrl_q[`MC_SLEW_BIT];
    assign output_invert        = mod_ctrl_q[`MC_OUT_INV_BIT];
    assign soft_data_value      = mod_ctrl_q[`MC_SOFT_BIT];
    assign carrier_high_sel             = carrier_high_ctrl_q[`CAR_SEL_LSB +: 3];
    assign carrier_high_invert  = carrier_high_ctrl_q[`CAR_INV_BIT];
    assign carrier_high_pin_cut = carrier_high_ctrl_q[`CAR_CUT_BIT];
    assign carrier_low_sel             = carrier_low_ctrl_q[`CAR_SEL_LSB +: 3];
    assign carrier_low_invert   = carrier_low_ctrl_q[`CAR_INV_BIT];
    assign carrier_low_pin_cut  = carrier_low_ctrl_q[`CAR_CUT_BIT];
    assign data_sel             = src_ctrl_q[`SRC_SEL_LSB +: 3];
    assign data_source_pin_cut  = src_ctrl_q[`SRC_CUT_BIT];

    // Only exact word offsets hit; anything else is refused with pslverr
    assign sel_mod  = (paddr == `ADDR_MOD_CTRL);
    assign sel_carrier_high = (paddr == `ADDR_CARRIER_HIGH_CTRL);
    assign sel_carrier_low = (paddr == `ADDR_CARRIER_LOW_CTRL);
    assign sel_src  = (paddr == `ADDR_SRC_CTRL);

    // One-wait-state APB: a request is taken in its first access cycle only,
    // pready feedback keeps a held request from being taken twice
    assign access = psel & penable & ~pready;
    assign wr_en  = access & pwrite;
    assign rd_en  = access & ~pwrite;

    // Sources come from other clock domains or pins
    keyer_sync2 #(.WIDTH(NSRC)) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (src_in),
        .sync_out (src_sync)
    );

    // No sleep gating anywhere: sleep_req is deliberately left unused
    keyer_mix #(.NSRC(NSRC)) u_mix (
        .sources         (src_sync),
        .carrier_high_sel        (carrier_high_sel),
        .carrier_low_sel        (carrier_low_sel),
        .data_sel        (data_sel),
        .carrier_high_inv        (carrier_high_invert),
        .carrier_low_inv        (carrier_low_invert),
        .keyer_enable    (keyer_enable),
        .soft_data_value (soft_data_value),
        .output_invert   (output_invert),
        .mod_sig         (),
        .mixed_out       (mixed)
    );

    always @*
    begin
        hit    = 1'h1;
        rd_mux = 8'h00;
        case (paddr)
            `ADDR_MOD_CTRL:  rd_mux = {mod_ctrl_q[7:4], status_q, 3'h0} |
                                      {7'h00, soft_data_value};
            `ADDR_CARRIER_HIGH_CTRL: rd_mux = carrier_high_ctrl_q;
            `ADDR_CARRIER_LOW_CTRL: rd_mux = carrier_low_ctrl_q;
            `ADDR_SRC_CTRL:  rd_mux = src_ctrl_q;
            default:         hit    = 1'h0;
        endcase
    end

    // Unmapped writes and all reads leave every register as it stands
    always @*
    begin
        mod_ctrl_d  = mod_ctrl_q;
        carrier_high_ctrl_d = carrier_high_ctrl_q;
        carrier_low_ctrl_d = carrier_low_ctrl_q;
        src_ctrl_d  = src_ctrl_q;
        if (wr_en)
        begin
            if (sel_mod)
                mod_ctrl_d = pwdata[7:0] & `MC_WMASK;
            if (sel_carrier_high)
                carrier_high_ctrl_d = pwdata[7:0] & `CAR_WMASK;
            if (sel_carrier_low)
                carrier_low_ctrl_d = pwdata[7:0] & `CAR_WMASK;
            if (sel_src)
                src_ctrl_d = pwdata[7:0] & `SRC_WMASK;
        end
    end

    always @*
    begin
        pready_d  = access;
        pslverr_d = access & ~hit;
        prdata_d  = prdata;
        // Read data stands until the next read, not only with pready
        if (rd_en)
            prdata_d = {24'h00_0000, rd_mux};
    end

    // Cuts only matter while the keyer is actually using that source
    generate
        for (g = 0; g < NSRC; g = g + 1)
        begin : g_cut
            localparam [31:0] IDX = g;
            wire high_hit;
            wire low_hit;
            wire data_hit;
            assign high_hit = carrier_high_pin_cut && (carrier_high_sel == IDX[2:0]);
            assign low_hit  = carrier_low_pin_cut && (carrier_low_sel == IDX[2:0]);
            // Select 0 is the software bit, which owns no pin
            assign data_hit = data_source_pin_cut && (data_sel == IDX[2:0])
                              && (data_sel != 3'h0);
            assign cut_d[g] = keyer_enable & (high_hit | low_hit | data_hit);
        end
    endgenerate

    always @*
    begin
        status_d = mixed;
        // Pin stays low while pin enable is clear, so firmware may configure first
        pin_d    = mixed & keyer_pin_enable;
        slew_d   = slew_limit_bit;
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mod_ctrl_q <= `MC_RESET;
        end
        else
        begin
            mod_ctrl_q <= mod_ctrl_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            carrier_high_ctrl_q <= `CAR_RESET;
        end
        else
        begin
            carrier_high_ctrl_q <= carrier_high_ctrl_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            carrier_low_ctrl_q <= `CAR_RESET;
        end
        else
        begin
            carrier_low_ctrl_q <= carrier_low_ctrl_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_ctrl_q <= `SRC_RESET;
        end
        else
        begin
            src_ctrl_q <= src_ctrl_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= pready_d;
            pslverr <= pslverr_d;
            prdata  <= prdata_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_q <= 1'h0;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            keyed_output_pin <= 1'h0;
        end
        else
        begin
            keyed_output_pin <= pin_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slew_limit_on <= 1'h1;
        end
        else
        begin
            slew_limit_on <= slew_d;
        end
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_pin_cut <= {NSRC{1'h0}};
        end
        else
        begin
            src_pin_cut <= cut_d;
        end
    end
endmodule
`default_nettype wire

// file: keyer_map.vh
/*
 Register map and field positions of the signal keyer control block.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef KEYER_MAP_VH
`define KEYER_MAP_VH
`define ADDR_MOD_CTRL      12'h000
`define ADDR_CARRIER_HIGH_CTRL     12'h004
`define ADDR_CARRIER_LOW_CTRL     12'h008
`define ADDR_SRC_CTRL      12'h00C
`define MC_ENABLE_BIT      7
`define MC_PIN_EN_BIT      6
`define MC_SLEW_BIT        5
`define MC_OUT_INV_BIT     4
`define MC_STATUS_BIT      3
`define MC_SOFT_BIT        0
`define MC_RESET           8'h20
`define MC_WMASK           8'hF1
`define CAR_SEL_LSB        0
`define CAR_INV_BIT        4
`define CAR_CUT_BIT        5
`define CAR_RESET          8'h00
`define CAR_WMASK          8'h37
`define SRC_SEL_LSB        0
`define SRC_CUT_BIT        7
`define SRC_RESET          8'h00
`define SRC_WMASK          8'h87
`endif

// file: keyer_sync2.v
/*
 Two-flop synchroniser, one per bit, for asynchronous source inputs.
 Assumes clk_sys and rst_n of the host block.
*/
`timescale 1ns/1ps
`default_nettype none
module keyer_sync2 #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end
                else
                begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate
endmodule
`default_nettype wire

// file: keyer_mix.v
/*
 Combinational keying core: carrier selection, inversion, data-driven carrier mux mixing.
 Assumes synchronised sources and registered controls on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module keyer_mix #(
    parameter NSRC = 8
) (
    input  wire [NSRC-1:0] sources,
    input  wire [2:0]      carrier_high_sel,
    input  wire [2:0]      carrier_low_sel,
    input  wire [2:0]      data_sel,
    input  wire            carrier_high_inv,
    input  wire            carrier_low_inv,
    input  wire            keyer_enable,
    input  wire            soft_data_value,
    input  wire            output_invert,
    output wire            mod_sig,
    output wire            mixed_out
);
    wire carrier_high_raw;
    wire carrier_low_raw;
    wire carrier_high;
    wire carrier_low;
    wire data_pick;
    // Disabled keyer grounds both carriers for least switching activity
    assign carrier_high_raw  = keyer_enable ? sources[carrier_high_sel] : 1'b0;
    assign carrier_low_raw  = keyer_enable ? sources[carrier_low_sel] : 1'b0;
    // Select 0 is the software data bit; stored selection is never touched
    assign data_pick = (data_sel == 3'h0) ? soft_data_value : sources[data_sel];
    assign mod_sig   = keyer_enable ? data_pick : soft_data_value;
    assign carrier_high      = carrier_high_raw ^ carrier_high_inv;
    assign carrier_low      = carrier_low_raw ^ carrier_low_inv;
    assign mixed_out = (mod_sig ? carrier_high : carrier_low) ^ output_invert;
endmodule
`default_nettype wire

// file: keyer_sources.sv
/*
 Source model for the keyer's src_in lines.
 Assumes the bench sets the wanted levels; they move on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module keyer_sources (
    input  wire logic       clk_sys,
    input  wire logic [7:0] want,
    output var  logic [7:0] src_in
);
    // Free running: sleep does not stop the sources
    always @(posedge clk_sys) src_in <= want;
endmodule
`default_nettype wire

// file: signal_keyer_asserts.sv
/*
 Port checker for signal_keyer: APB answer timing and pin controls.
 Assumes the master holds each request until pready.
*/
`include "keyer_map.vh"
`timescale 1ns/1ps
`default_nettype none
module keyer_checker (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        keyed_output_pin,
    input wire logic        slew_limit_on
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire acc = psel && penable && !pready;
    wire mcw = acc && pwrite && paddr == `ADDR_MOD_CTRL;
    wire rdq = pready && !pwrite;
    property p_answer; acc |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_err; acc && paddr > `ADDR_SRC_CTRL |=> pready && pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_err_pair; pslverr |-> pready; endproperty
    a_err_pair: assert property (p_err_pair) else $error("pslverr without pready");
    property p_hi_zero; rdq |-> prdata[31:8] == 24'h000000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("read bits above 7 set");
    property p_rsv; rdq && paddr == `ADDR_MOD_CTRL |-> prdata[2:1] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
    property p_slew_rst; $rose(rst_n) |-> slew_limit_on && !keyed_output_pin; endproperty
    a_slew_rst: assert property (p_slew_rst) else $error("bad pins after reset");
    property p_slew_clr; mcw && !pwdata[`MC_SLEW_BIT] |=> ##1 !slew_limit_on; endproperty
    a_slew_clr: assert property (p_slew_clr) else $error("slew line stays up");
    property p_pin_off; mcw && !pwdata[`MC_PIN_EN_BIT] |=> ##1 !keyed_output_pin; endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin not held low");
endmodule
bind signal_keyer keyer_checker u_chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .keyed_output_pin, .slew_limit_on);
`default_nettype wire

// file: test_signal_keyer.sv
/*
 Self-checking bench for signal_keyer with a register and keying model.
 Assumes keyer_sources drives src_in and the checker is bound in.
*/
`include "keyer_map.vh"
`timescale 1ns/1ps
`default_nettype none
module test_signal_keyer;
    logic        clk_sys = 0, rst_n = 0, sleep_req = 0;
    logic        psel = 0, penable = 0, pwrite = 0, er, slverr, pin, slew;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, seed = 41296;
    logic [7:0]  want = 0, src_in, cut;
    int          mismatches = 0, comparisons = 0, cycles = 0, mc, ch, cl, ds, m, h, l, o;
    signal_keyer DUT (.clk_sys, .rst_n, .sleep_req, .src_in, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata(rd), .pready(er), .pslverr(slverr), .keyed_output_pin(pin),
        .slew_limit_on(slew), .src_pin_cut(cut));
    keyer_sources u_src (.clk_sys, .want, .src_in);
    always #25 clk_sys = ~clk_sys;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task tally_and_finish();
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until pready is sampled high at a rising edge, then released
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (er !== 1'b1) @(posedge clk_sys);
        r = {slverr, rd};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task check_all();
        logic [32:0] r;
        m = mc[7] ? (ds[2:0] == 0 ? mc[0] : want[ds[2:0]]) : mc[0];
        h = (mc[7] & want[ch[2:0]]) ^ ch[4];
        l = (mc[7] & want[cl[2:0]]) ^ cl[4];
        o = (m ? h : l) ^ mc[4];
        apb(0, `ADDR_MOD_CTRL, 0, r);
        chk(r, mc | o << 3);
        apb(0, `ADDR_CARRIER_HIGH_CTRL, 0, r);
        chk(r, ch);
        apb(0, `ADDR_CARRIER_LOW_CTRL, 0, r);
        chk(r, cl);
        apb(0, `ADDR_SRC_CTRL, 0, r);
        chk(r, ds);
        @(negedge clk_sys);
        chk(pin, o & mc[6]);
        chk(slew, mc[5]);
        chk(cut, mc[7] ? ch[5] << ch[2:0] | cl[5] << cl[2:0] |
            (ds[7] && ds[2:0] != 0) << ds[2:0] : 0);
    endtask
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial
    begin
        logic [32:0] r;
        mc = `MC_RESET;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_all();
        apb(1, 12'h010, 32'hFFFFFFFF, r);
        chk(r, 33'h1_0000_0000);
        apb(0, 12'h010, 0, r);
        chk(r, 33'h1_0000_0000);
        for (int i = 0; i < 48; i++)
        begin
            @(posedge clk_sys);
            want <= 8'(rnd());
            sleep_req <= seed[3];
            ds = rnd() & `SRC_WMASK;
            apb(1, `ADDR_SRC_CTRL, seed, r);
            ch = rnd() & `CAR_WMASK;
            apb(1, `ADDR_CARRIER_HIGH_CTRL, seed, r);
            cl = rnd() & `CAR_WMASK;
            apb(1, `ADDR_CARRIER_LOW_CTRL, seed, r);
            mc = rnd() & `MC_WMASK;
            // Pin enable goes last so a newly enabled pin never shows a stale setup
            apb(1, `ADDR_MOD_CTRL, seed, r);
            check_all();
        end
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        mc = `MC_RESET;
        {ch, cl, ds} = 96'h0;
        check_all();
        tally_and_finish();
    end
endmodule
`default_nettype wire
